// File: hw/stack_entry_bank.sv
// Sequencer stack entries seven to nine with APB access and walker
// What this block does
// RQ1 - Bit 15 of each entry holds the access direction, zero read, one write.
// RQ2 - Host puts target register address in bits 14 to 9 to select it.
// RQ3 - Return bit clear: step to the next entry after the conversion ends.
// RQ4 - Return bit set: go back to the first entry after the conversion ends.
// RQ5 - Bits 7 to 4 choose the converter B input while the entry is active.
// RQ6 - Bits 3 to 0 choose the converter A input while the entry is active.
// RQ7 - Entry seven resets to 0x4F77: return set, both selects seven.
// RQ8 - Entry eight resets to 0x5000: own address only, return and selects clear.
// RQ9 - Entry nine resets to 0x5200: own address only, return and selects clear.
// RQ10 - Apply both selects at conversion start, evaluate return bit at its end.
`timescale 1ns/1ns
`default_nettype none

module stack_entry_bank #(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              conv_start,
	input  wire logic              conv_done,
	input  wire logic              stack_restart,
	input  wire logic [15:0]       other_entry_word,
	output logic [3:0]             stack_pointer,
	output logic [3:0]             converter_a_input_choice,
	output logic [3:0]             converter_b_input_choice,
	output logic                   selects_applied
);

	// Field extraction, used for the live entry and for status
	function automatic logic wrap_of(input logic [15:0] w);
		wrap_of = w[stack_entry_pkg::WRAP_BIT];
	endfunction

	function automatic logic [3:0] cha_of(input logic [15:0] w);
		cha_of = w[stack_entry_pkg::CHA_HI:stack_entry_pkg::CHA_LO];
	endfunction

	function automatic logic [3:0] chb_of(input logic [15:0] w);
		chb_of = w[stack_entry_pkg::CHB_HI:stack_entry_pkg::CHB_LO];
	endfunction

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = ADDR_W'({4'h0, idx} << stack_entry_pkg::ADDR_SHIFT);
	endfunction

	// Storage
	logic [15:0]       entry_q [stack_entry_pkg::LOCAL_N];
	logic [3:0]        ptr_q;
	logic [3:0]        ptr_d;
	logic [3:0]        cha_q;
	logic [3:0]        chb_q;
	logic              applied_q;
	logic              pready_q;
	logic [31:0]       prdata_q;
	logic              pslverr_q;

	// Address decode
	wire logic         hit_7;
	wire logic         hit_8;
	wire logic         hit_9;
	wire logic         hit_status;
	wire logic         hit_any;
	wire logic         setup_phase;
	wire logic         access_done;
	wire logic         wr_ok;
	wire logic         lane_lo;
	wire logic         lane_hi;

	assign hit_7       = paddr == byte_addr(stack_entry_pkg::IDX_ENTRY_7);
	assign hit_8       = paddr == byte_addr(stack_entry_pkg::IDX_ENTRY_8);
	assign hit_9       = paddr == byte_addr(stack_entry_pkg::IDX_ENTRY_9);
	assign hit_status  = paddr == byte_addr(stack_entry_pkg::IDX_STATUS);
	assign hit_any     = hit_7 | hit_8 | hit_9 | hit_status;
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready_q;
	// Status is read-only, so a write there is refused like an unmapped one
	assign wr_ok       = access_done & pwrite & ~pslverr_q;
	assign lane_lo     = pstrb[0];
	assign lane_hi     = pstrb[1];

	// Per-entry write enables
	wire logic [2:0]   wr_entry;

	assign wr_entry[0] = wr_ok & hit_7;
	assign wr_entry[1] = wr_ok & hit_8;
	assign wr_entry[2] = wr_ok & hit_9;

	// Byte-lane merge of write data into an entry
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic        lo,
		input logic        hi
	);
		merge = {hi ? wd[15:8] : old[15:8], lo ? wd[7:0] : old[7:0]};
	endfunction

	// Next value of each entry, merged per byte lane
	// Only lanes 0 and 1 carry entry bits; upper lanes are ignored
	wire logic [15:0]  entry_7_d;
	wire logic [15:0]  entry_8_d;
	wire logic [15:0]  entry_9_d;

	assign entry_7_d = merge(entry_q[0], pwdata, lane_lo, lane_hi); // RQ1
	assign entry_8_d = merge(entry_q[1], pwdata, lane_lo, lane_hi); // RQ1
	assign entry_9_d = merge(entry_q[2], pwdata, lane_lo, lane_hi); // RQ1

	// Entry seven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry_q[0] <= stack_entry_pkg::RST_ENTRY_7; // RQ7
		end else if (wr_entry[0]) begin
			entry_q[0] <= entry_7_d;
		end
	end

	// Entry eight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry_q[1] <= stack_entry_pkg::RST_ENTRY_8; // RQ8
		end else if (wr_entry[1]) begin
			entry_q[1] <= entry_8_d;
		end
	end

	// Entry nine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry_q[2] <= stack_entry_pkg::RST_ENTRY_9; // RQ9
		end else if (wr_entry[2]) begin
			entry_q[2] <= entry_9_d;
		end
	end

	// Live entry selection: local words for pointers seven to nine
	wire logic         ptr_local;
	wire logic [3:0]   ptr_off;
	wire logic [1:0]   local_idx;
	wire logic [15:0]  live_word;
	wire logic [15:0]  local_word;

	assign ptr_off   = ptr_q - stack_entry_pkg::PTR_LOCAL_0;
	assign ptr_local = ptr_q >= stack_entry_pkg::PTR_LOCAL_0 &&
		ptr_off < 4'(stack_entry_pkg::LOCAL_N);
	assign local_idx = ptr_off[1:0];
	assign local_word = entry_q[local_idx];
	// Pointer outside seven to nine takes its word from the far side
	assign live_word = ptr_local ? local_word : other_entry_word;

	// Next pointer after a finished conversion
	wire logic         live_wrap;
	wire logic [3:0]   ptr_step;

	assign live_wrap = wrap_of(live_word);
	assign ptr_step  = ptr_q + 4'h1;

	// Select fields of the live entry and the next select values
	wire logic [3:0]   live_cha;
	wire logic [3:0]   live_chb;
	wire logic [3:0]   cha_d;
	wire logic [3:0]   chb_d;
	wire logic         applied_d;

	assign live_cha  = cha_of(live_word);
	assign live_chb  = chb_of(live_word);
	// Both selects move on the same edge, never one without the other
	assign cha_d     = conv_start ? live_cha : cha_q; // RQ6
	assign chb_d     = conv_start ? live_chb : chb_q; // RQ5
	assign applied_d = conv_start; // RQ10

	always_comb begin
		ptr_d = ptr_q;
		if (stack_restart) begin
			// Restart beats a conversion end in the same cycle
			ptr_d = stack_entry_pkg::PTR_FIRST;
		end else if (conv_done) begin
			if (live_wrap) begin
				ptr_d = stack_entry_pkg::PTR_FIRST; // RQ4
			end else begin
				ptr_d = ptr_step; // RQ3
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= stack_entry_pkg::PTR_FIRST;
		end else begin
			ptr_q <= ptr_d; // RQ10
		end
	end

	// Channel selects latch at conversion start and hold through it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cha_q <= 4'h0;
			chb_q <= 4'h0;
		end else if (conv_start) begin
			cha_q <= cha_d;
			chb_q <= chb_d;
		end
	end

	// One-cycle marker that both selects were applied together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied_q <= 1'b0;
		end else begin
			applied_q <= applied_d;
		end
	end

	// Status word reflects the walker's own state
	wire logic [31:0]  status_word;

	wire logic [31:0]  st_ptr;
	wire logic [31:0]  st_cha;
	wire logic [31:0]  st_chb;
	wire logic [31:0]  st_local;
	wire logic [31:0]  st_wrap;

	assign st_ptr      = 32'(ptr_q) << stack_entry_pkg::ST_PTR_LO;
	assign st_cha      = 32'(cha_q) << stack_entry_pkg::ST_CHA_LO;
	assign st_chb      = 32'(chb_q) << stack_entry_pkg::ST_CHB_LO;
	assign st_local    = 32'(ptr_local) << stack_entry_pkg::ST_LOCAL;
	assign st_wrap     = 32'(live_wrap) << stack_entry_pkg::ST_WRAP;
	assign status_word = st_ptr | st_cha | st_chb | st_local | st_wrap;

	// Read mux, narrow words in the low bits and zeros above
	wire logic [31:0]  read_word;
	wire logic         bad_access;
	wire logic [31:0]  rd_entry_7;
	wire logic [31:0]  rd_entry_8;
	wire logic [31:0]  rd_entry_9;

	assign rd_entry_7 = 32'(entry_q[0]);
	assign rd_entry_8 = 32'(entry_q[1]);
	assign rd_entry_9 = 32'(entry_q[2]);
	assign read_word =
		hit_7      ? rd_entry_7 :
		hit_8      ? rd_entry_8 :
		hit_9      ? rd_entry_9 :
		hit_status ? status_word :
		stack_entry_pkg::DATA_ZERO;
	assign bad_access = ~hit_any | (hit_status & pwrite);

	// Zero-wait APB answer: data and error prepared in the setup cycle.
	// Status sampled at setup may be one cycle old; acceptable for polling.
	wire logic         pready_d;
	wire logic [31:0]  prdata_d;
	wire logic         pslverr_d;

	assign pready_d  = setup_phase;
	assign prdata_d  = (setup_phase && !pwrite) ? read_word : prdata_q;
	// Error set at setup also blocks the store in the access cycle
	assign pslverr_d = setup_phase ? bad_access : (access_done ? 1'b0 : pslverr_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= stack_entry_pkg::DATA_ZERO;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= pslverr_d;
		end
	end

	// Outputs
	assign pready                   = pready_q;
	assign prdata                   = prdata_q;
	assign pslverr                  = pslverr_q;
	assign stack_pointer            = ptr_q;
	assign converter_a_input_choice = cha_q;
	assign converter_b_input_choice = chb_q;
	assign selects_applied          = applied_q;

endmodule

`default_nettype wire

// File: hw/stack_entry_pkg.sv
// Constants for the sequencer stack entries seven to nine
package stack_entry_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_ENTRY_7 = 8'h27;
	localparam logic [7:0] IDX_ENTRY_8 = 8'h28;
	localparam logic [7:0] IDX_ENTRY_9 = 8'h29;
	localparam logic [7:0] IDX_STATUS  = 8'h30;
	localparam int         ADDR_SHIFT  = 2;

	// Word layout of a stack entry
	localparam int ENTRY_W     = 16;
	localparam int DIR_BIT     = 15;
	localparam int SELF_HI     = 14;
	localparam int SELF_LO     = 9;
	localparam int WRAP_BIT    = 8;
	localparam int CHB_HI      = 7;
	localparam int CHB_LO      = 4;
	localparam int CHA_HI      = 3;
	localparam int CHA_LO      = 0;
	localparam int CH_W        = 4;

	// Reset values
	localparam logic [15:0] RST_ENTRY_7 = 16'h4F77;
	localparam logic [15:0] RST_ENTRY_8 = 16'h5000;
	localparam logic [15:0] RST_ENTRY_9 = 16'h5200;

	// Stack pointer
	localparam int         PTR_W       = 4;
	localparam logic [3:0] PTR_FIRST   = 4'h0;
	localparam logic [3:0] PTR_LOCAL_0 = 4'h7;
	localparam int         LOCAL_N     = 3;

	// Status register layout
	localparam int ST_PTR_LO   = 0;
	localparam int ST_CHA_LO   = 4;
	localparam int ST_CHB_LO   = 8;
	localparam int ST_LOCAL    = 12;
	localparam int ST_WRAP     = 13;

	// Bus
	localparam int         DATA_W    = 32;
	localparam int         ADDR_W    = 12;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

// File: test/stack_entry_bank_assertions.sv
// Port-level checks for the stack entry bank
`timescale 1ns/1ns
`default_nettype none
module stack_entry_bank_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        conv_start,
	input wire logic        conv_done,
	input wire logic        stack_restart,
	input wire logic [15:0] other_entry_word,
	input wire logic [3:0]  stack_pointer,
	input wire logic [3:0]  converter_a_input_choice,
	input wire logic [3:0]  converter_b_input_choice,
	input wire logic        selects_applied
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic ext;
	// Local entries are not visible at the ports, so only outside words are predicted
	assign ext = stack_pointer < 4'h7 || stack_pointer > 4'h9;
	sequence s_step; conv_done && !stack_restart && ext && !other_entry_word[8]; endsequence
	sequence s_wrap; conv_done && ext && other_entry_word[8]; endsequence
	property p_next; s_step |=> stack_pointer == $past(stack_pointer) + 4'h1; endproperty
	property p_wrap; s_wrap |=> stack_pointer == 4'h0; endproperty
	property p_restart; stack_restart |=> stack_pointer == 4'h0; endproperty
	property p_hold; !conv_done && !stack_restart |=> $stable(stack_pointer); endproperty
	property p_cha;
		conv_start && ext |=> converter_a_input_choice == $past(other_entry_word[3:0]);
	endproperty
	property p_chb;
		conv_start && ext |=> converter_b_input_choice == $past(other_entry_word[7:4]);
	endproperty
	property p_pulse; conv_start |=> selects_applied; endproperty
	property p_quiet;
		!conv_start |=> !selects_applied && $stable(converter_a_input_choice)
			&& $stable(converter_b_input_choice);
	endproperty
	a_next: assert property (p_next) else $error("pointer did not step");
	a_hold: assert property (p_hold) else $error("pointer moved unasked");
	a_wrap: assert property (p_wrap) else $error("pointer did not return");
	a_restart: assert property (p_restart) else $error("restart ignored");
	a_cha: assert property (p_cha) else $error("wrong A select");
	a_chb: assert property (p_chb) else $error("wrong B select");
	a_pulse: assert property (p_pulse) else $error("no applied pulse");
	a_quiet: assert property (p_quiet) else $error("selects changed unasked");
endmodule
bind stack_entry_bank stack_entry_bank_chk u_chk (.*);
`default_nettype wire

// File: test/seq_env_model.sv
// Far-side model holding the stack entries outside seven to nine
`timescale 1ns/1ns
`default_nettype none
module seq_env_model (
	input  wire logic [3:0]  stack_pointer,
	output logic      [15:0] other_entry_word
);
	logic [15:0] words [16];
	// Local entries live in the bank, so the inverted word stands there
	assign other_entry_word = (stack_pointer inside {4'h7, 4'h8, 4'h9}) ?
		~words[stack_pointer] : words[stack_pointer];
endmodule
`default_nettype wire

// File: test/test_channel_sequence_stack_entries.sv
// Self-checking bench for the stack entry bank
`timescale 1ns/1ns
`default_nettype none
module test_channel_sequence_stack_entries;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        conv_start, conv_done, stack_restart, selects_applied;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, stack_pointer, converter_a_input_choice, converter_b_input_choice;
	logic [15:0] other_entry_word, ent [3], w;
	int          miscompares, checks, p, n;
	stack_entry_bank u_dut (.*);
	seq_env_model u_env (.*);
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %0t: %h not %h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'h1, wr, a, d, s};
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 9);
		if (n >= 9) begin
			miscompares++;
			end_sim();
		end
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd_chk(input int i);
		apb(1'h0, 12'h09C + 12'(4 * i), $urandom, 4'hF);
		chk(rd, {16'h0000, ent[i]});
		chk(er, 1'h0);
	endtask
	task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
		apb(1'h1, 12'h09C + 12'(4 * i), d, s);
		ent[i] = {s[1] ? d[15:8] : ent[i][15:8], s[0] ? d[7:0] : ent[i][7:0]};
		chk(er, 1'h0);
		rd_chk(i);
	endtask
	task automatic conv(input logic rs);
		w = (p >= 7 && p <= 9) ? ent[p - 7] : u_env.words[p];
		@(posedge pclk);
		conv_start <= 1'h1;
		@(posedge pclk);
		{conv_start, conv_done, stack_restart} <= {2'h1, rs};
		@(posedge pclk);
		{conv_done, stack_restart} <= 2'h0;
		chk(converter_a_input_choice, w[3:0]);
		chk(converter_b_input_choice, w[7:4]);
		chk(selects_applied, 1'h1);
		p = (rs || w[8]) ? 0 : (p + 1) % 16;
		@(posedge pclk);
		chk(stack_pointer, p[3:0]);
		apb(1'h0, 12'h0C0, $urandom, 4'hF);
		chk(rd, {18'h0, (p >= 7 && p <= 9) ? ent[p - 7][8] : u_env.words[p][8],
			1'(p >= 7 && p <= 9), w[7:4], w[3:0], p[3:0]});
		chk(er, 1'h0);
	endtask
	initial begin
		{miscompares, checks, p} = 0;
		{psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = 0;
		{conv_start, conv_done, stack_restart} = 3'h0;
		ent = '{16'h4F77, 16'h5000, 16'h5200};
		rd = $urandom(70497);
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 3; i++)
			rd_chk(i);
		apb(1'h0, 12'h0A8, 32'h0, 4'hF);
		chk(rd, 32'h0);
		chk(er, 1'h1);
		apb(1'h1, 12'h0C0, 32'hFFFF, 4'hF);
		chk(er, 1'h1);
		$display("test reset and refusals done");
		repeat (12) wr($urandom % 3, $urandom, $urandom);
		$display("test writes done");
		// Low entries never wrap, so the walk reaches the local entries
		for (int i = 0; i < 16; i++)
			u_env.words[i] = 16'($urandom) & (i < 7 ? 16'hFEFF : 16'hFFFF);
		repeat (60) conv($urandom % 16 == 0);
		$display("test walk done");
		end_sim();
	end
endmodule
`default_nettype wire
